//--- rtl/ftd_pkg.sv
// constants shared by the frame timing divider and its reference chain
package ftd_pkg;

  // ****************************************
  // clock and divider chain
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int REF_MHZ = 5;
  localparam int REF_DIV_DEF = CLK_MHZ / REF_MHZ;
  localparam int LOW_DIV_DEF = 50;
  localparam int MULT_DEF = 3;
  localparam int FRAME_DIV_DEF = 15625;
  localparam int SUPER_DIV = 3;
  localparam int TICK_KHZ = REF_MHZ * 1000 * MULT_DEF / LOW_DIV_DEF;

  // ****************************************
  // frame windows, times in us, counts in metered ticks
  // ****************************************
  localparam int CMD_US = 1000;
  localparam int CMD_TICKS = CMD_US * TICK_KHZ / 1000;
  localparam int TX_LEAD_US = 106;
  localparam int TX_LEAD_TICKS = (TX_LEAD_US * TICK_KHZ + 999) / 1000;
  localparam int TX_LAG_US = 16;
  localparam int TX_LAG_TICKS = (TX_LAG_US * TICK_KHZ + 999) / 1000;
  localparam int INV_LEAD_US = 106;
  localparam int INV_LEAD_TICKS = (INV_LEAD_US * TICK_KHZ + 999) / 1000;
  localparam int INV_END_US = 1497;
  localparam int INV_END_TICKS = (INV_END_US * TICK_KHZ + 999) / 1000;

  // ****************************************
  // pulse and timeout timing
  // ****************************************
  localparam int FSP_NS = 400;
  localparam int FSP_CYCLES = (FSP_NS * CLK_MHZ + 999) / 1000;
  localparam int MS_CYCLES_DEF = CLK_MHZ * 1000;
  localparam int TIMEOUT_S = 20;
  localparam int FORCE_S = 1;
  localparam int TIMEOUT_MS_DEF = TIMEOUT_S * 1000;
  localparam int FORCE_MS_DEF = FORCE_S * 1000;
  localparam int HIST_W_DEF = 8;

  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam int CTRL_RESYNC_BIT = 0;
  localparam int CTRL_HOLDRX_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int STAT_OOS_BIT = 0;
  localparam int STAT_ACQ_BIT = 1;
  localparam int STAT_FORCE_BIT = 2;
  localparam int STAT_REMOTE_BIT = 3;
  localparam int STAT_HIST_LSB = 8;

  // ****************************************
  // timeout states
  // ****************************************
  typedef enum logic [2:0] {
    TMO_IDLE = 3'b001,
    TMO_WAIT = 3'b010,
    TMO_FORCE = 3'b100
  } ftd_tmo_t;

endpackage : ftd_pkg

//--- rtl/ftd_ref_chain.sv
// reference divider: 5 MHz enable, divide by 50, times-three metering
`timescale 1ns/1ps
`default_nettype none

module ftd_ref_chain
  import ftd_pkg::*;
#(
  parameter int REF_DIV = REF_DIV_DEF,
  parameter int LOW_DIV = LOW_DIV_DEF,
  parameter int MULT = MULT_DEF
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic syncLoad,
  output logic refTick,
  output logic fastTick,
  output logic refClk,
  output logic lowClk
);

  localparam int RW = $clog2(REF_DIV);
  localparam int LW = $clog2(LOW_DIV);
  localparam int MW = $clog2(MULT + 1);

  logic [RW-1:0] refCnt_r;
  logic [LW-1:0] lowCnt_r;
  logic [MW-1:0] meter_r;
  logic refLast;
  logic lowFall;

  // ****************************************
  // elaboration checks
  // ****************************************
  if (REF_DIV < 2 || LOW_DIV < 2 * MULT + 2 || MULT < 1)
  begin : g_bad
    $error("ftd_ref_chain: divider parameters out of range");
  end

  assign refLast = (refCnt_r == RW'(REF_DIV - 1));
  assign lowFall = refLast && (lowCnt_r == LW'(LOW_DIV / 2 - 1));

  // core clock divided down to the reference rate; load puts phase at a rising edge
  always_ff @(posedge core_clk)
  begin
    if (rst || syncLoad || refLast)
      refCnt_r <= '0;
    else
      refCnt_r <= refCnt_r + 1'b1;
  end

  // divide by 50 gives the 100 kHz square wave
  always_ff @(posedge core_clk)
  begin
    if (rst || syncLoad)
      lowCnt_r <= '0;
    else if (refLast)
      lowCnt_r <= (lowCnt_r == LW'(LOW_DIV - 1)) ? '0 : lowCnt_r + 1'b1;
  end

  // each falling edge of 100 kHz meters out three reference pulses
  always_ff @(posedge core_clk)
  begin
    if (rst || syncLoad)
      meter_r <= '0;
    else if (lowFall)
      meter_r <= MW'(MULT);
    else if (refLast && meter_r != '0)
      meter_r <= meter_r - 1'b1;
  end

  // registered strobes and clocks; ticks land on reference rising edges
  always_ff @(posedge core_clk)
  begin
    if (rst || syncLoad)
    begin
      refTick <= 1'b0;
      fastTick <= 1'b0;
      refClk <= 1'b1;
      lowClk <= 1'b1;
    end
    else
    begin
      refTick <= refLast;
      fastTick <= refLast && (meter_r != '0);
      refClk <= refLast || (refCnt_r < RW'(REF_DIV / 2 - 1));
      lowClk <= lowCnt_r < LW'(LOW_DIV / 2);
    end
  end

endmodule : ftd_ref_chain

`default_nettype wire

//--- rtl/ftd_divider_sync.sv
// frame timing divider with remote sync acquisition and monitoring
//
// Overview of operation
// [RQ1] frame repeats at 19.2 Hz
// [RQ2] command window lasts 1000 us per frame
// [RQ3] frame sync pulse initialises divider circuitry everywhere
// [RQ4] 5 MHz clock supplied to communication units
// [RQ5] central transmit from -106 us to +16 us after
// [RQ6] remote held in receive during command window
// [RQ7] out of sync: force receive 1 s every 20 s
// [RQ8] carrier gate rises on 5 MHz rising edge
// [RQ9] 6.4 Hz super-cycle marks specific reference cycles
// [RQ10] leading detected carrier edge is received sync
// [RQ11] narrow monitoring when synced, wide acquisition otherwise; the code acquires wide only while the history is all ones
// [RQ12] eight errors lose sync, eight detections regain
// [RQ13] track/hold strobes valid only after sync
// [RQ14] oscillator locks unaided before sync achieved
// [RQ15] central payload invalid from -106 to +1497 us
// [RQ16] correlator inhibits integration while payload invalid
// [RQ17] remote 100 kHz clock, 50% duty, sync locked
// [RQ18] sync status bit exposed for monitor word
// [RQ19] remote 9.6 Hz square wave to front ends
// [RQ20] divide 50, meter times three, divide 15625
// [RQ21] good shifts zero, bad shifts one; ones acquire
// [RQ22] frame sync pulse positive, 400 ns long
// [RQ23] strap low is free master, open remote
// [RQ24] reset starts in acquisition, out of sync
//
// The Wishbone register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module ftd_divider_sync
  import ftd_pkg::*;
#(
  parameter int FRAME_DIV = FRAME_DIV_DEF,
  parameter int MS_CYCLES = MS_CYCLES_DEF,
  parameter int TIMEOUT_MS = TIMEOUT_MS_DEF,
  parameter int FORCE_MS = FORCE_MS_DEF,
  parameter int HIST_W = HIST_W_DEF
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic strapOpen,
  input wire logic detectedCarrierIn,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic frameSyncPulse,
  output logic refClkOut,
  output logic transmitSelect,
  output logic carrierGateOut,
  output logic superCycleOut,
  output logic centralTrackHold,
  output logic remoteTrackHold,
  output logic payloadInvalid,
  output logic clk100kOut,
  output logic square9p6Out,
  output logic frameRateOut,
  output logic syncError,
  output logic syncTimeout
);

  localparam int FW = $clog2(FRAME_DIV);
  localparam int PW = $clog2(MS_CYCLES);
  localparam int TW = $clog2(TIMEOUT_MS + FORCE_MS + 1);
  localparam int QW = $clog2(FSP_CYCLES + 1);
  localparam logic [FW-1:0] FRAME_LAST = FW'(FRAME_DIV - 1);
  localparam logic [FW-1:0] CMD_END = FW'(CMD_TICKS);
  localparam logic [FW-1:0] TX_ON = FW'(FRAME_DIV - TX_LEAD_TICKS);
  localparam logic [FW-1:0] TX_OFF = FW'(CMD_TICKS + TX_LAG_TICKS);
  localparam logic [FW-1:0] INV_ON = FW'(FRAME_DIV - INV_LEAD_TICKS);
  localparam logic [FW-1:0] INV_OFF = FW'(INV_END_TICKS);
  localparam logic [FW-1:0] HALF_FRAME = FW'(FRAME_DIV / 2);

  // ****************************************
  // elaboration checks
  // ****************************************
  if (FRAME_DIV <= INV_END_TICKS + INV_LEAD_TICKS || HIST_W < 2 ||
      MS_CYCLES < 2 || TIMEOUT_MS < 1 || FORCE_MS < 1)
  begin : g_bad
    $error("ftd_divider_sync: parameters out of range");
  end

  logic refTick;
  logic fastTick;
  logic refClk;
  logic lowClk;
  logic syncLoad;
  logic isRemote_r;
  logic carrierPrev_r;
  logic carrierRise;
  logic [FW-1:0] frameCnt_r;
  logic [1:0] superPh_r;
  logic half9p6_r;
  logic frameWrap;
  logic firstRef_r;
  logic onTime_r;
  logic decide;
  logic [HIST_W-1:0] hist_r;
  logic acquire;
  logic outOfSync_r;
  logic [QW-1:0] fspCnt_r;
  ftd_tmo_t tmoState_r;
  logic [PW-1:0] msCnt_r;
  logic msTick;
  logic [TW-1:0] tmoCnt_r;
  logic forceRx;
  logic [1:0] ctrl_r;
  logic resyncReq;
  logic inCmd;
  logic rxWindow;
  logic busHit;

  // ****************************************
  // reference chain
  // ****************************************
  // reference, 100 kHz and metered 300 kHz ticks see RQ20
  ftd_ref_chain #(
    .REF_DIV(REF_DIV_DEF),
    .LOW_DIV(LOW_DIV_DEF),
    .MULT(MULT_DEF)
  ) u_chain (
    .core_clk(core_clk),
    .rst(rst),
    .syncLoad(syncLoad),
    .refTick(refTick),
    .fastTick(fastTick),
    .refClk(refClk),
    .lowClk(lowClk)
  );

  // ****************************************
  // role strap and carrier edge
  // ****************************************
  // strap is a level; sampled every cycle so it is taken after reset too
  always_ff @(posedge core_clk)
  begin
    if (rst)
      isRemote_r <= 1'b0;
    else
      isRemote_r <= strapOpen; // see RQ23
  end

  // only the rising edge of the detected carrier counts as received sync
  always_ff @(posedge core_clk)
  begin
    if (rst)
      carrierPrev_r <= 1'b0;
    else
      carrierPrev_r <= detectedCarrierIn;
  end

  assign carrierRise = detectedCarrierIn && !carrierPrev_r; // see RQ10

  // ****************************************
  // frame counter and super-cycle
  // ****************************************
  assign frameWrap = fastTick && (frameCnt_r == FRAME_LAST);
  assign inCmd = frameCnt_r < CMD_END; // see RQ2
  assign rxWindow = inCmd || forceRx || ctrl_r[CTRL_HOLDRX_BIT];
  // wide-band mode: any received edge while listening reloads the dividers
  assign acquire = (hist_r == '1); // see RQ11
  assign syncLoad = (isRemote_r && acquire && rxWindow && carrierRise) ||
                    resyncReq; // see RQ3

  // divide metered ticks by the frame length; wrap is the predicted sync
  always_ff @(posedge core_clk)
  begin
    if (rst || syncLoad)
      frameCnt_r <= '0;
    else if (frameWrap)
      frameCnt_r <= '0; // see RQ1
    else if (fastTick)
      frameCnt_r <= frameCnt_r + 1'b1;
  end

  // three frames form the super-cycle; the 9.6 Hz wave toggles per frame
  always_ff @(posedge core_clk)
  begin
    if (rst || syncLoad)
    begin
      superPh_r <= '0;
      half9p6_r <= 1'b0;
    end
    else if (frameWrap)
    begin
      superPh_r <= (superPh_r == 2'(SUPER_DIV - 1)) ? '0 : superPh_r + 1'b1; // see RQ9
      half9p6_r <= !half9p6_r; // see RQ19
    end
  end

  // ****************************************
  // sync comparison
  // ****************************************
  // the predicted sync spans the one reference cycle after the frame start
  always_ff @(posedge core_clk)
  begin
    if (rst)
      firstRef_r <= 1'b0;
    else if (syncLoad || frameWrap)
      firstRef_r <= 1'b1;
    else if (refTick)
      firstRef_r <= 1'b0;
  end

  assign decide = fastTick && (frameCnt_r == '0);

  // edge inside the predicted cycle is good; set wins over the clear
  always_ff @(posedge core_clk)
  begin
    if (rst)
      onTime_r <= 1'b0;
    else if (carrierRise && (syncLoad || (firstRef_r && frameCnt_r == '0)))
      onTime_r <= 1'b1; // see RQ10
    else if (decide)
      onTime_r <= 1'b0;
  end

  // history: good shifts a zero right, bad shifts a one left
  always_ff @(posedge core_clk)
  begin
    if (rst)
      hist_r <= '1; // see RQ24
    else if (resyncReq)
      hist_r <= '1;
    else if (decide)
    begin
      if (!isRemote_r || onTime_r)
        hist_r <= {1'b0, hist_r[HIST_W-1:1]}; // see RQ21
      else
        hist_r <= {hist_r[HIST_W-2:0], 1'b1}; // see RQ21
    end
  end

  // flag rises only when full of ones and falls only when all zero
  always_ff @(posedge core_clk)
  begin
    if (rst)
      outOfSync_r <= 1'b1; // see RQ24
    else if (hist_r == '1)
      outOfSync_r <= 1'b1; // see RQ12
    else if (hist_r == '0)
      outOfSync_r <= 1'b0; // see RQ12
  end

  // ****************************************
  // frame sync pulse
  // ****************************************
  // 400 ns pulse from each frame start or reload
  always_ff @(posedge core_clk)
  begin
    if (rst)
      fspCnt_r <= '0;
    else if (frameWrap || syncLoad)
      fspCnt_r <= QW'(FSP_CYCLES); // see RQ22
    else if (fspCnt_r != '0)
      fspCnt_r <= fspCnt_r - 1'b1;
  end

  // ****************************************
  // out-of-sync receive timeout
  // ****************************************
  // millisecond prescaler, free of the sync reloads so it never stalls
  always_ff @(posedge core_clk)
  begin
    if (rst || msTick)
      msCnt_r <= '0;
    else
      msCnt_r <= msCnt_r + 1'b1;
  end

  assign msTick = (msCnt_r == PW'(MS_CYCLES - 1));
  assign forceRx = (tmoState_r == TMO_FORCE);

  // wait the long timeout, then hold receive; repeats while out of sync
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      tmoState_r <= TMO_IDLE;
      tmoCnt_r <= '0;
    end
    else if (!isRemote_r || !outOfSync_r)
    begin
      tmoState_r <= TMO_IDLE;
      tmoCnt_r <= '0;
    end
    else
    begin
      unique case (tmoState_r)
        TMO_IDLE:
        begin
          tmoState_r <= TMO_WAIT;
          tmoCnt_r <= '0;
        end
        TMO_WAIT:
        begin
          if (msTick && tmoCnt_r == TW'(TIMEOUT_MS - 1))
          begin
            tmoState_r <= TMO_FORCE; // see RQ7
            tmoCnt_r <= '0;
          end
          else if (msTick)
            tmoCnt_r <= tmoCnt_r + 1'b1;
        end
        TMO_FORCE:
        begin
          if (msTick && tmoCnt_r == TW'(FORCE_MS - 1))
          begin
            tmoState_r <= TMO_WAIT; // see RQ7
            tmoCnt_r <= '0;
          end
          else if (msTick)
            tmoCnt_r <= tmoCnt_r + 1'b1;
        end
        default:
        begin
          tmoState_r <= TMO_IDLE;
          tmoCnt_r <= '0;
        end
      endcase
    end
  end

  // ****************************************
  // register slave
  // ****************************************
  assign busHit = cyc_i && stb_i && !ack_o;
  assign resyncReq = busHit && we_i && sel_i[0] && adr_i == CTRL_OFS &&
                     dat_i[CTRL_RESYNC_BIT];

  // control: resync is a strobe, hold-receive is kept
  always_ff @(posedge core_clk)
  begin
    if (rst)
      ctrl_r <= CTRL_RESET;
    else if (busHit && we_i && sel_i[0] && adr_i == CTRL_OFS)
      ctrl_r[CTRL_HOLDRX_BIT] <= dat_i[CTRL_HOLDRX_BIT];
  end

  // one-cycle answer; unmapped reads return zero, writes are dropped
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end
    else
    begin
      ack_o <= busHit;
      dat_o <= '0;
      if (busHit && !we_i && adr_i == CTRL_OFS)
        dat_o[1:0] <= {ctrl_r[CTRL_HOLDRX_BIT], 1'b0};
      else if (busHit && !we_i && adr_i == STAT_OFS)
      begin
        dat_o[STAT_OOS_BIT] <= outOfSync_r; // see RQ18
        dat_o[STAT_ACQ_BIT] <= acquire;
        dat_o[STAT_FORCE_BIT] <= forceRx;
        dat_o[STAT_REMOTE_BIT] <= isRemote_r;
        dat_o[STAT_HIST_LSB +: HIST_W] <= hist_r;
      end
    end
  end

  // ****************************************
  // output decode
  // ****************************************
  // every pin is registered; windows that span the wrap use two compares
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      frameSyncPulse <= 1'b0;
      refClkOut <= 1'b0;
      transmitSelect <= 1'b0;
      carrierGateOut <= 1'b0;
      superCycleOut <= 1'b0;
      centralTrackHold <= 1'b0;
      remoteTrackHold <= 1'b0;
      payloadInvalid <= 1'b0;
      clk100kOut <= 1'b0;
      square9p6Out <= 1'b0;
      frameRateOut <= 1'b0;
      syncError <= 1'b1;
      syncTimeout <= 1'b0;
    end
    else
    begin
      frameSyncPulse <= fspCnt_r != '0; // see RQ3
      refClkOut <= refClk; // see RQ4
      if (isRemote_r)
        transmitSelect <= !rxWindow; // see RQ6
      else
        transmitSelect <= frameCnt_r < TX_OFF || frameCnt_r >= TX_ON; // see RQ5
      // counter moves only on ticks that fall on reference rising edges
      carrierGateOut <= !isRemote_r && inCmd; // see RQ8
      superCycleOut <= superPh_r == '0; // see RQ9
      centralTrackHold <= !isRemote_r && !outOfSync_r && inCmd; // see RQ13
      // oscillator must lock unaided until this strobe is valid, see RQ14
      remoteTrackHold <= isRemote_r && !outOfSync_r && inCmd; // see RQ13
      payloadInvalid <= !isRemote_r &&
                        (frameCnt_r < INV_OFF || frameCnt_r >= INV_ON); // see RQ15
      clk100kOut <= isRemote_r && lowClk; // see RQ17
      square9p6Out <= isRemote_r && half9p6_r; // see RQ19
      frameRateOut <= frameCnt_r < HALF_FRAME; // see RQ1
      syncError <= outOfSync_r; // see RQ18
      syncTimeout <= forceRx; // see RQ7
    end
  end

endmodule : ftd_divider_sync

`default_nettype wire

//--- tb/ftd_divider_sync_properties.sv
// concurrent checks on the frame timing divider ports
`timescale 1ns/1ps
`default_nettype none

module ftd_divider_sync_properties
  import ftd_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF,
  parameter int FORCE_MS = FORCE_MS_DEF
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic strapOpen,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic frameSyncPulse,
  input wire logic refClkOut,
  input wire logic transmitSelect,
  input wire logic carrierGateOut,
  input wire logic payloadInvalid,
  input wire logic centralTrackHold,
  input wire logic remoteTrackHold,
  input wire logic clk100kOut,
  input wire logic square9p6Out,
  input wire logic syncError,
  input wire logic syncTimeout
);
  // ****************************************
  // run-length counters
  // ****************************************
  logic [15:0] fspRun_r;
  logic [15:0] refHi_r;
  logic [31:0] tmoRun_r;

  // lengths of the current high runs; pulses are too long for repetition
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      fspRun_r <= 16'h0;
      refHi_r <= 16'h0;
      tmoRun_r <= 32'h0;
    end
    else
    begin
      fspRun_r <= frameSyncPulse ? fspRun_r + 16'h1 : 16'h0;
      refHi_r <= refClkOut ? refHi_r + 16'h1 : 16'h0;
      tmoRun_r <= syncTimeout ? tmoRun_r + 32'h1 : 32'h0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // ****************************************
  // assertions
  // ****************************************
  a_ack_next_cycle: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not acknowledged next cycle");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("acknowledge longer than one cycle");
  a_dat_idle_zero: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data not zero outside acknowledge");
  a_fsp_width: assert property ($fell(frameSyncPulse) |-> fspRun_r == 16'(FSP_CYCLES))
    else $error("frame sync pulse width wrong");
  // a reload realigns the reference phase, so runs inside a sync pulse are skipped
  a_ref_half: assert property ($fell(refClkOut) && !frameSyncPulse
    |-> refHi_r == 16'(REF_DIV_DEF / 2))
    else $error("reference clock high phase wrong");
  a_sync_after_reset: assert property ($past(rst) |-> syncError)
    else $error("out-of-sync flag clear after reset");
  a_hold_needs_sync: assert property (syncError && $past(syncError)
    |-> !centralTrackHold && !remoteTrackHold)
    else $error("track hold active while out of sync");
  a_remote_no_gate: assert property (strapOpen [*4]
    |-> !carrierGateOut && !payloadInvalid && !centralTrackHold)
    else $error("central output active in remote role");
  a_central_no_remote: assert property ((!strapOpen) [*4]
    |-> !clk100kOut && !square9p6Out && !syncTimeout && !remoteTrackHold)
    else $error("remote output active in central role");
  a_force_receive: assert property (syncTimeout && $past(syncTimeout) |-> !transmitSelect)
    else $error("transmit while timeout forces receive");
  a_force_width: assert property ($fell(syncTimeout)
    |-> tmoRun_r == 32'(FORCE_MS * MS_CYCLES))
    else $error("forced receive length wrong");
endmodule : ftd_divider_sync_properties

bind ftd_divider_sync ftd_divider_sync_properties #(
  .MS_CYCLES(MS_CYCLES),
  .FORCE_MS(FORCE_MS)
) u_props (
  .core_clk(core_clk),
  .rst(rst),
  .strapOpen(strapOpen),
  .cyc_i(cyc_i),
  .stb_i(stb_i),
  .dat_o(dat_o),
  .ack_o(ack_o),
  .frameSyncPulse(frameSyncPulse),
  .refClkOut(refClkOut),
  .transmitSelect(transmitSelect),
  .carrierGateOut(carrierGateOut),
  .payloadInvalid(payloadInvalid),
  .centralTrackHold(centralTrackHold),
  .remoteTrackHold(remoteTrackHold),
  .clk100kOut(clk100kOut),
  .square9p6Out(square9p6Out),
  .syncError(syncError),
  .syncTimeout(syncTimeout)
);

`default_nettype wire

//--- tb/ftd_carrier_model.sv
// far-side model: detected carrier bursts as seen from the link receiver
`timescale 1ns/1ps
`default_nettype none

module ftd_carrier_model
#(
  parameter int BURST = 200
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic burstReq,
  input wire logic [7:0] lagCycles,
  output logic detectedCarrierIn
);
  logic pend_r;
  logic [7:0] lag_r;
  logic [15:0] left_r;

  // a request starts one burst after a lag, so prompt and slow answers occur
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pend_r <= 1'b0;
      lag_r <= 8'h0;
      left_r <= 16'h0;
    end
    else if (burstReq)
    begin
      pend_r <= 1'b1;
      lag_r <= lagCycles;
    end
    else if (pend_r)
    begin
      pend_r <= (lag_r != 8'h0);
      lag_r <= lag_r - 8'h1;
      left_r <= (lag_r == 8'h0) ? 16'(BURST) : 16'h0;
    end
    else if (left_r != 16'h0)
      left_r <= left_r - 16'h1;
  end

  // detector output is low with no carrier, one clean rising edge per burst
  assign detectedCarrierIn = (left_r != 16'h0);
endmodule : ftd_carrier_model

`default_nettype wire

//--- tb/ftd_tb.sv
// self-checking testbench for the frame timing divider
`timescale 1ns/1ps
`default_nettype none

module tb;
  import ftd_pkg::*;
  localparam int MSC = 10;
  localparam int FRC = 2;
  logic core_clk = 0, rst = 1, strapOpen = 0, burstReq = 0, carrier;
  logic cyc = 0, stb = 0, we = 0, ack, holdExp = 0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0, rd, rdat, d;
  logic [7:0] lag = 8'h0;
  logic fsp, refClk, txSel, gate, superC, central_track_hold, rth, inval, c100k, sq, rate, sErr, sTmo;
  int nErrors = 0, checksDone = 0, seed = 43321, n;

  ftd_divider_sync #(.FRAME_DIV(600), .MS_CYCLES(MSC), .TIMEOUT_MS(3), .FORCE_MS(FRC)) dut (
    .core_clk(core_clk), .rst(rst), .strapOpen(strapOpen), .detectedCarrierIn(carrier),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(wdat), .sel_i(sel),
    .dat_o(rdat), .ack_o(ack), .frameSyncPulse(fsp), .refClkOut(refClk),
    .transmitSelect(txSel), .carrierGateOut(gate), .superCycleOut(superC),
    .centralTrackHold(central_track_hold), .remoteTrackHold(rth), .payloadInvalid(inval),
    .clk100kOut(c100k), .square9p6Out(sq), .frameRateOut(rate), .syncError(sErr),
    .syncTimeout(sTmo));

  ftd_carrier_model u_link (.core_clk(core_clk), .rst(rst), .burstReq(burstReq),
    .lagCycles(lag), .detectedCarrierIn(carrier));

  initial forever #5 core_clk = ~core_clk;

  // ****************************************
  // helpers
  // ****************************************
  task automatic printVerdict;
    $display("checks %0d errors %0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : printVerdict

  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    checksDone++;
    if (seen !== expv)
    begin
      nErrors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask : check

  task automatic bail;
    nErrors++;
    printVerdict();
  endtask : bail

  // classic single cycle; returns at the edge that sampled ack
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] dv,
                    input logic [3:0] s);
    int k;
    k = 0;
    @(posedge core_clk);
    {cyc, stb, we, adr, wdat, sel} <= {1'b1, 1'b1, w, a, dv, s};
    do
    begin
      @(posedge core_clk);
      if (++k > 50) bail();
    end while (ack !== 1'b1);
    rd = rdat;
    {cyc, stb, we} <= 3'b000;
  endtask : wb

  function automatic logic pick(input int k);
    return (k == 0) ? fsp : ((k == 1) ? c100k : sTmo);
  endfunction : pick

  function automatic logic [31:0] ctrlRead(input logic hold);
    return {30'h0, hold, 1'b0};
  endfunction : ctrlRead

  // length of the next complete high run, partial runs skipped
  task automatic runLen(input int k, output int len);
    int b;
    b = 0;
    len = 0;
    while (pick(k) === 1'b1) begin @(posedge core_clk); if (++b > 3000) bail(); end
    while (pick(k) !== 1'b1) begin @(posedge core_clk); if (++b > 6000) bail(); end
    while (pick(k) === 1'b1) begin @(posedge core_clk); if (++len > 3000) bail(); end
  endtask : runLen

  // resync strobe; the pulse starts in the cycle after the acknowledge cycle
  task automatic resync;
    int len;
    len = 0;
    wb(1'b1, CTRL_OFS, 32'h1, 4'h1);
    // the pulse register is loaded at the ack edge, so look one edge later
    @(posedge core_clk);
    while (fsp === 1'b1) begin len++; @(posedge core_clk); if (len > 100) bail(); end
    check(32'(len), 32'(FSP_CYCLES));
  endtask : resync

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    wb(1'b0, STAT_OFS, 32'h0, 4'hf);
    check(rd, 32'h0000ff03);
    wb(1'b0, 4'h8, 32'h0, 4'hf);
    check(rd, 32'h0);
    // random hold-receive writes, writes without byte lane 0 must be ignored
    repeat (8)
    begin
      d = $random(seed) & 32'hfffffffe;
      n = $random(seed);
      wb(1'b1, CTRL_OFS, d, n[3:0]);
      if (n[0]) holdExp = d[1];
      wb(1'b0, CTRL_OFS, 32'h0, 4'hf);
      check(rd, ctrlRead(holdExp));
    end
    wb(1'b1, CTRL_OFS, 32'h0, 4'h1);
    resync();
    repeat (5) @(posedge core_clk);
    check({gate, txSel, inval, rate, central_track_hold, sErr, c100k, superC}, 8'hf5);
    strapOpen <= 1'b1;
    repeat (5) @(posedge core_clk);
    resync();
    repeat (5) @(posedge core_clk);
    check({txSel, gate, inval, central_track_hold, rth, sErr, sq}, 7'h02);
    wb(1'b0, STAT_OFS, 32'h0, 4'hf);
    check(rd & 32'hfffffffb, 32'h0000ff0b);
    runLen(1, n);
    check(32'(n), 32'(LOW_DIV_DEF / 2 * REF_DIV_DEF));
    runLen(2, n);
    check(32'(n), 32'(FRC * MSC));
    // carrier edge while acquiring reloads the dividers
    lag <= 8'($random(seed)) & 8'h0f;
    burstReq <= 1'b1;
    @(posedge core_clk);
    burstReq <= 1'b0;
    runLen(0, n);
    check(32'(n), 32'(FSP_CYCLES));
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    check({sErr, txSel}, 2'b10);
    printVerdict();
  end
endmodule : tb

`default_nettype wire
